// ===== core/asm_slot_mapper.sv
// Purpose: slot and output line mapping for audio channels 2 to 4
// Assumes: frame timing supplies a slot strobe with slot position
// Notes:   lowest channel wins if two share a slot on one line
//
// What this block does
// R01: fields 0..31 are left slots 0..31
// R02: fields 32..63 are right slots 0..31
// R03: tdm slot index equals the field
// R04: middle field values map linearly too
// R05: line bit clear drives primary output
// R06: line bit set drives secondary output
// R07: slot bits 5:0, line bit 6, bit7 zero
// R08: channel 3 resets to slot 2, primary
// R09: channel 4 resets to slot 3, primary
// R10: channel 2 resets to slot 1, primary
// R11: software keeps slots unique per line
`timescale 1ns/10ps
module asm_slot_mapper (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        reg_wr_en_in,
  input  wire logic        reg_rd_en_in,
  input  wire logic [7:0]  reg_page_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [7:0]  reg_rdata_out,
  output logic             reg_rd_valid_out,
  input  wire logic [2:0]  fmt_in,
  input  wire logic        slot_strobe_in,
  input  wire logic        frame_half_in,
  input  wire logic [5:0]  slot_pos_in,
  input  wire logic [31:0] chan_b_sample_in,
  input  wire logic [31:0] chan_c_sample_in,
  input  wire logic [31:0] chan_d_sample_in,
  output logic      [31:0] primary_serial_word_out,
  output logic             primary_serial_valid_out,
  output logic      [31:0] secondary_out_word_out,
  output logic             secondary_out_valid_out
);

  typedef struct packed {
    logic [7:0]  rdata;
    logic        rd_valid;
    logic [31:0] pri_word;
    logic        pri_valid;
    logic [31:0] sec_word;
    logic        sec_valid;
  } asm_map_s;

  asm_map_s state_r;
  asm_map_s state_nxt;

  // ==========================================================
  // register decode
  logic       page_ok;
  logic [2:0] wr_sel;
  logic [7:0] chan_b_value;
  logic [7:0] chan_c_value;
  logic [7:0] chan_d_value;

  assign page_ok   = (reg_page_in == asm_pkg::PAGE_CFG);
  assign wr_sel[0] = reg_wr_en_in && page_ok && (reg_addr_in == asm_pkg::OFS_CHAN_B);
  assign wr_sel[1] = reg_wr_en_in && page_ok && (reg_addr_in == asm_pkg::OFS_CHAN_C);
  assign wr_sel[2] = reg_wr_en_in && page_ok && (reg_addr_in == asm_pkg::OFS_CHAN_D);

  // ==========================================================
  // channel registers
  logic [5:0] chan_b_slot_index;
  logic [5:0] chan_c_slot_index;
  logic [5:0] chan_d_slot_index;
  logic       chan_b_line_select;
  logic       chan_c_line_select;
  logic       chan_d_line_select;

  asm_chan_reg #(.RST_VAL(asm_pkg::RST_CHAN_B)) u_reg_b (
    .clk_in          (clk_in),
    .reset_n_in      (reset_n_in),
    .wr_en_in        (wr_sel[0]),
    .wdata_in        (reg_wdata_in),
    .slot_index_out  (chan_b_slot_index),
    .line_select_out (chan_b_line_select),
    .value_out       (chan_b_value)
  );

  asm_chan_reg #(.RST_VAL(asm_pkg::RST_CHAN_C)) u_reg_c (
    .clk_in          (clk_in),
    .reset_n_in      (reset_n_in),
    .wr_en_in        (wr_sel[1]),
    .wdata_in        (reg_wdata_in),
    .slot_index_out  (chan_c_slot_index),
    .line_select_out (chan_c_line_select),
    .value_out       (chan_c_value)
  );

  asm_chan_reg #(.RST_VAL(asm_pkg::RST_CHAN_D)) u_reg_d (
    .clk_in          (clk_in),
    .reset_n_in      (reset_n_in),
    .wr_en_in        (wr_sel[2]),
    .wdata_in        (reg_wdata_in),
    .slot_index_out  (chan_d_slot_index),
    .line_select_out (chan_d_line_select),
    .value_out       (chan_d_value)
  );

  // ==========================================================
  // slot matching, one matcher per channel
  logic [2:0] hit;

  asm_slot_match u_match_b (
    .fmt_in        (fmt_in),
    .frame_half_in (frame_half_in),
    .slot_pos_in   (slot_pos_in),
    .slot_index_in (chan_b_slot_index),
    .hit_out       (hit[0])
  );

  asm_slot_match u_match_c (
    .fmt_in        (fmt_in),
    .frame_half_in (frame_half_in),
    .slot_pos_in   (slot_pos_in),
    .slot_index_in (chan_c_slot_index),
    .hit_out       (hit[1])
  );

  asm_slot_match u_match_d (
    .fmt_in        (fmt_in),
    .frame_half_in (frame_half_in),
    .slot_pos_in   (slot_pos_in),
    .slot_index_in (chan_d_slot_index),
    .hit_out       (hit[2])
  );

  // ==========================================================
  // line steering: split each hit by the channel's line bit
  logic [2:0]  on_sec;
  logic [2:0]  pri_hit;
  logic [2:0]  sec_hit;
  logic [31:0] sample [3];

  assign on_sec    = {chan_d_line_select, chan_c_line_select, chan_b_line_select};
  assign pri_hit   = hit & ~on_sec; // R05
  assign sec_hit   = hit & on_sec;  // R06
  assign sample[0] = chan_b_sample_in;
  assign sample[1] = chan_c_sample_in;
  assign sample[2] = chan_d_sample_in;

  // ==========================================================
  // next state: register reads and slot words
  // a shared slot is undefined for software; the lowest channel
  // wins so the output stays a clean word, never an or of two
  always_comb begin
    state_nxt          = state_r;
    state_nxt.rd_valid = reg_rd_en_in;
    if (reg_rd_en_in) begin
      state_nxt.rdata = 8'h00; // unmapped page or offset
      if (page_ok) begin
        unique case (reg_addr_in)
          asm_pkg::OFS_CHAN_B: state_nxt.rdata = chan_b_value; // R07
          asm_pkg::OFS_CHAN_C: state_nxt.rdata = chan_c_value;
          asm_pkg::OFS_CHAN_D: state_nxt.rdata = chan_d_value;
          default:             state_nxt.rdata = 8'h00;
        endcase
      end
    end
    state_nxt.pri_valid = slot_strobe_in && (|pri_hit); // R05
    state_nxt.sec_valid = slot_strobe_in && (|sec_hit); // R06
    if (slot_strobe_in) begin
      for (int i = asm_pkg::NUM_CH - 1; i >= 0; i--) begin
        if (pri_hit[i]) begin
          state_nxt.pri_word = sample[i]; // R05
        end
        if (sec_hit[i]) begin
          state_nxt.sec_word = sample[i]; // R06
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata_out            = state_r.rdata;
  assign reg_rd_valid_out         = state_r.rd_valid;
  assign primary_serial_word_out  = state_r.pri_word;
  assign primary_serial_valid_out = state_r.pri_valid;
  assign secondary_out_word_out   = state_r.sec_word;
  assign secondary_out_valid_out  = state_r.sec_valid;

  // ==========================================================
  // assertions
  logic split_fmt;
  assign split_fmt = (fmt_in == asm_pkg::ASM_FMT_I2S) || (fmt_in == asm_pkg::ASM_FMT_LJ);

  property p_left_slot;
    @(posedge clk_in) disable iff (!reset_n_in)
    slot_strobe_in && split_fmt && !frame_half_in && !slot_pos_in[5]
      && !chan_b_line_select && (chan_b_slot_index == slot_pos_in)
    |=> primary_serial_valid_out && (primary_serial_word_out == $past(chan_b_sample_in));
  endproperty
  a_left_slot: assert property (p_left_slot) else $error("left slot not placed"); // R01

  property p_right_slot;
    @(posedge clk_in) disable iff (!reset_n_in)
    slot_strobe_in && split_fmt && frame_half_in && !slot_pos_in[5]
      && !chan_b_line_select && (chan_b_slot_index == (slot_pos_in + asm_pkg::HALF_SLOTS))
    |=> primary_serial_valid_out && (primary_serial_word_out == $past(chan_b_sample_in));
  endproperty
  a_right_slot: assert property (p_right_slot) else $error("right slot not placed"); // R02

  property p_tdm_slot;
    @(posedge clk_in) disable iff (!reset_n_in)
    slot_strobe_in && (fmt_in == asm_pkg::ASM_FMT_TDM)
      && !chan_b_line_select && (chan_b_slot_index == slot_pos_in)
    |=> primary_serial_valid_out && (primary_serial_word_out == $past(chan_b_sample_in));
  endproperty
  a_tdm_slot: assert property (p_tdm_slot) else $error("tdm slot not placed"); // R03

  property p_no_stray;
    @(posedge clk_in) disable iff (!reset_n_in)
    slot_strobe_in && (fmt_in == asm_pkg::ASM_FMT_TDM)
      && (chan_b_slot_index != slot_pos_in) && (chan_c_slot_index != slot_pos_in)
      && (chan_d_slot_index != slot_pos_in)
    |=> !primary_serial_valid_out && !secondary_out_valid_out;
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("word in unowned slot"); // R04

  property p_primary_line;
    @(posedge clk_in) disable iff (!reset_n_in)
    slot_strobe_in && hit[1] && !hit[0] && !chan_c_line_select
    |=> primary_serial_valid_out && (primary_serial_word_out == $past(chan_c_sample_in));
  endproperty
  a_primary_line: assert property (p_primary_line) else $error("primary line missed"); // R05

  property p_secondary_line;
    @(posedge clk_in) disable iff (!reset_n_in)
    slot_strobe_in && hit[0] && chan_b_line_select
    |=> secondary_out_valid_out && (secondary_out_word_out == $past(chan_b_sample_in));
  endproperty
  a_secondary_line: assert property (p_secondary_line) else $error("secondary line missed"); // R06

  property p_readback;
    @(posedge clk_in) disable iff (!reset_n_in)
    reg_rd_en_in && page_ok && (reg_addr_in == asm_pkg::OFS_CHAN_D)
    |=> reg_rd_valid_out && !reg_rdata_out[asm_pkg::RSVD_BIT]
      && (reg_rdata_out[5:0] == $past(chan_d_slot_index))
      && (reg_rdata_out[6] == $past(chan_d_line_select));
  endproperty
  a_readback: assert property (p_readback) else $error("register readback wrong"); // R07

  // a write lands next cycle with the reserved bit dropped, so software sees it at once
  property p_write_lands;
    @(posedge clk_in) disable iff (!reset_n_in)
    wr_sel[2]
    |=> (chan_d_value == {1'b0, $past(reg_wdata_in[asm_pkg::LINE_BIT:asm_pkg::SLOT_LSB])});
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("register write not stored"); // R07

  // a slot nobody owns must not disturb the word the host last saw
  property p_word_hold;
    @(posedge clk_in) disable iff (!reset_n_in)
    slot_strobe_in && !(|pri_hit)
    |=> !primary_serial_valid_out && $stable(primary_serial_word_out);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("primary word moved without owner"); // R05

  property p_reset_c;
    @(posedge clk_in) $rose(reset_n_in) |-> (chan_c_value == asm_pkg::RST_CHAN_C);
  endproperty
  a_reset_c: assert property (p_reset_c) else $error("channel 3 reset value wrong"); // R08

  property p_reset_d;
    @(posedge clk_in) $rose(reset_n_in) |-> (chan_d_value == asm_pkg::RST_CHAN_D);
  endproperty
  a_reset_d: assert property (p_reset_d) else $error("channel 4 reset value wrong"); // R09

  property p_reset_b;
    @(posedge clk_in) $rose(reset_n_in) |-> (chan_b_value == asm_pkg::RST_CHAN_B);
  endproperty
  a_reset_b: assert property (p_reset_b) else $error("channel 2 reset value wrong"); // R10

  // main scenarios
  property p_cov_tdm;
    @(posedge clk_in) disable iff (!reset_n_in)
    slot_strobe_in && (fmt_in == asm_pkg::ASM_FMT_TDM) && (|pri_hit);
  endproperty
  c_cov_tdm: cover property (p_cov_tdm);

  property p_cov_right;
    @(posedge clk_in) disable iff (!reset_n_in)
    slot_strobe_in && split_fmt && frame_half_in && (|hit);
  endproperty
  c_cov_right: cover property (p_cov_right);

  property p_cov_sec;
    @(posedge clk_in) disable iff (!reset_n_in)
    slot_strobe_in && (|sec_hit);
  endproperty
  c_cov_sec: cover property (p_cov_sec);

  property p_cov_lj;
    @(posedge clk_in) disable iff (!reset_n_in)
    slot_strobe_in && (fmt_in == asm_pkg::ASM_FMT_LJ) && (|hit);
  endproperty
  c_cov_lj: cover property (p_cov_lj);

endmodule // asm_slot_mapper

// ===== include/asm_pkg.sv
// Purpose: shared constants and types of the audio slot mapper
// Assumes: one clock, registers on page 0 of the control port
// Notes:   channels b, c, d are audio channels 2, 3, 4
package asm_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] PAGE_CFG     = 8'h00;
  localparam logic [7:0] OFS_CHAN_B   = 8'h0c;
  localparam logic [7:0] OFS_CHAN_C   = 8'h0d;
  localparam logic [7:0] OFS_CHAN_D   = 8'h0e;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CHAN_B   = 8'h01;
  localparam logic [7:0] RST_CHAN_C   = 8'h02;
  localparam logic [7:0] RST_CHAN_D   = 8'h03;

  // ==========================================================
  // field layout
  localparam int SLOT_LSB  = 0;
  localparam int SLOT_MSB  = 5;
  localparam int HALF_BIT  = 5;
  localparam int LINE_BIT  = 6;
  localparam int RSVD_BIT  = 7;
  localparam logic [5:0] HALF_SLOTS = 6'h20;

  // ==========================================================
  // widths
  localparam int NUM_CH    = 3;
  localparam int SAMPLE_W  = 32;

  // frame formats, one-hot
  typedef enum logic [2:0] {
    ASM_FMT_TDM = 3'b001,
    ASM_FMT_I2S = 3'b010,
    ASM_FMT_LJ  = 3'b100
  } asm_fmt_e;

endpackage

// ===== core/asm_chan_reg.sv
// Purpose: one per-channel slot and line control register
// Assumes: write strobe already decoded for this register
// Notes:   reserved bit is not stored and reads as zero
`timescale 1ns/10ps
module asm_chan_reg #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       wr_en_in,
  input  wire logic [7:0] wdata_in,
  output logic      [5:0] slot_index_out,
  output logic            line_select_out,
  output logic      [7:0] value_out
);

  typedef struct packed {
    logic [5:0] slot;
    logic       line;
  } asm_creg_s;

  asm_creg_s state_r;
  asm_creg_s state_nxt;

  // ==========================================================
  // next state: software write replaces both fields
  always_comb begin
    state_nxt = state_r;
    if (wr_en_in) begin
      state_nxt.slot = wdata_in[asm_pkg::SLOT_MSB:asm_pkg::SLOT_LSB]; // R07
      state_nxt.line = wdata_in[asm_pkg::LINE_BIT];                   // R07
    end
  end

  // reset loads the channel's own default slot, primary line
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r.slot <= RST_VAL[asm_pkg::SLOT_MSB:asm_pkg::SLOT_LSB]; // R08 R09 R10
      state_r.line <= RST_VAL[asm_pkg::LINE_BIT];
    end else begin
      state_r <= state_nxt;
    end
  end

  assign slot_index_out  = state_r.slot;
  assign line_select_out = state_r.line;
  // reserved top bit reads zero
  assign value_out       = {1'b0, state_r.line, state_r.slot}; // R07

endmodule // asm_chan_reg

// ===== core/asm_slot_match.sv
// Purpose: decide whether a channel owns the slot now on the wire
// Assumes: slot position counts from 0 within a half in i2s and lj
// Notes:   pure combinational, no state
`timescale 1ns/10ps
module asm_slot_match (
  input  wire logic [2:0] fmt_in,
  input  wire logic       frame_half_in,
  input  wire logic [5:0] slot_pos_in,
  input  wire logic [5:0] slot_index_in,
  output logic            hit_out
);

  // ==========================================================
  // slot decode: tdm is linear, i2s and lj split on the top bit
  function automatic logic slot_hit(
    input logic [2:0] fmt,
    input logic       half,
    input logic [5:0] pos,
    input logic [5:0] idx
  );
    logic r;
    r = 1'b0;
    unique case (fmt)
      asm_pkg::ASM_FMT_TDM: begin
        r = (pos == idx); // R03
      end
      asm_pkg::ASM_FMT_I2S, asm_pkg::ASM_FMT_LJ: begin
        // field 0..31 is left, 32..63 is right slot 0..31
        r = !pos[asm_pkg::HALF_BIT]
            && (half == idx[asm_pkg::HALF_BIT])                        // R01 R02
            && (pos[4:0] == idx[4:0]);                                 // R04
      end
      default: begin
        r = 1'b0; // illegal format code places nothing
      end
    endcase
    return r;
  endfunction

  assign hit_out = slot_hit(fmt_in, frame_half_in, slot_pos_in, slot_index_in);

endmodule // asm_slot_match

// ===== testbench/asm_host_rx.sv
// Purpose: host side receiver that collects the words of both output lines
// Assumes: each word arrives with a one-cycle valid from the mapper
// Notes:   keeps counts and xor sums only, no frame timing of its own
`timescale 1ns/10ps
module asm_host_rx (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        pri_valid_in,
  input  wire logic [31:0] pri_word_in,
  input  wire logic        sec_valid_in,
  input  wire logic [31:0] sec_word_in,
  output logic      [15:0] pri_count_out,
  output logic      [15:0] sec_count_out,
  output logic      [31:0] pri_sum_out,
  output logic      [31:0] sec_sum_out
);
  typedef struct packed {
    logic [15:0] pn;
    logic [15:0] sn;
    logic [31:0] px;
    logic [31:0] sx;
  } asm_rx_s;
  asm_rx_s st_r;
  asm_rx_s st_nxt;
  // ==========================================================
  // collection: a sum catches a wrong word even when counts agree
  always_comb begin
    st_nxt = st_r;
    if (pri_valid_in) begin
      st_nxt.pn = st_r.pn + 16'h0001;
      st_nxt.px = st_r.px ^ pri_word_in;
    end
    if (sec_valid_in) begin
      st_nxt.sn = st_r.sn + 16'h0001;
      st_nxt.sx = st_r.sx ^ sec_word_in;
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign pri_count_out = st_r.pn;
  assign sec_count_out = st_r.sn;
  assign pri_sum_out   = st_r.px;
  assign sec_sum_out   = st_r.sx;
endmodule // asm_host_rx

// ===== testbench/tb.sv
// Purpose: self-checking bench for the slot and line mapper
// Assumes: inputs change at the falling edge, outputs read one cycle later
// Notes:   every slot of every format is swept with strobes back to back
`timescale 1ns/10ps
module tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        strobe = 1'b0;
  logic        half = 1'b0;
  logic [7:0]  page = 8'h00;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [2:0]  fmt = 3'h1;
  logic [5:0]  pos = 6'h00;
  logic [31:0] smp [3] = '{default: 32'h0};
  logic [7:0]  rdata;
  logic        rd_valid, pv, sv;
  logic [31:0] pw, sw, px, sx;
  logic [15:0] pn, sn;
  logic [31:0] exp_pw = 32'h0, exp_sw = 32'h0, exp_px = 32'h0, exp_sx = 32'h0;
  logic [15:0] exp_pn = 16'h0, exp_sn = 16'h0;
  int          fail_count = 0;
  int          checked = 0;
  // configs give each line unique slots; field ends, middles, bit 7 set
  // second set puts channel 2 on a right-half slot of the primary line
  logic [7:0]  cfg [3][3] = '{'{8'h01, 8'h02, 8'h03}, '{8'h20, 8'h1f, 8'hff}, '{8'h62, 8'h1e, 8'h3e}};
  logic [2:0]  fmts [4] = '{3'h1, 3'h2, 3'h4, 3'h3};

  asm_slot_mapper asm_slot_mapper_inst (
    .clk_in(clk), .reset_n_in(reset_n), .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en),
    .reg_page_in(page), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_rd_valid_out(rd_valid), .fmt_in(fmt), .slot_strobe_in(strobe), .frame_half_in(half),
    .slot_pos_in(pos), .chan_b_sample_in(smp[0]), .chan_c_sample_in(smp[1]), .chan_d_sample_in(smp[2]),
    .primary_serial_word_out(pw), .primary_serial_valid_out(pv),
    .secondary_out_word_out(sw), .secondary_out_valid_out(sv));
  asm_host_rx asm_host_rx_inst (
    .clk_in(clk), .reset_n_in(reset_n), .pri_valid_in(pv), .pri_word_in(pw), .sec_valid_in(sv),
    .sec_word_in(sw), .pri_count_out(pn), .sec_count_out(sn), .pri_sum_out(px), .sec_sum_out(sx));

  // ==========================================================
  // clock and shared tasks
  always #5 clk = ~clk;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1; page = pg; addr = a; wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  // answer stands for one cycle, so it is read at the next falling edge
  task automatic rd(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd_en = 1'b1; page = pg; addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    chk("rd_valid", 32'(rd_valid), 32'h1);
    chk("rdata", 32'(rdata), 32'(exp));
  endtask

  // reference mapping worked out from the field layout
  function automatic logic owns(input logic [2:0] f, input logic h, input logic [5:0] p, input logic [5:0] fld);
    if (f == 3'h1) return p == fld;
    if (f == 3'h2 || f == 3'h4) return (p < 6'h20) && ({h, p[4:0]} == fld);
    return 1'b0;
  endfunction

  task automatic chk_out(input logic ep, input logic es);
    chk("pri_valid", 32'(pv), 32'(ep));
    chk("pri_word", pw, exp_pw);
    chk("sec_valid", 32'(sv), 32'(es));
    chk("sec_word", sw, exp_sw);
  endtask

  // one strobe per cycle; the previous slot is checked before the next is set
  task automatic stream(input logic [2:0] f, input int c);
    logic ep, es, pp, ps;
    pp = 1'b0;
    ps = 1'b0;
    for (int h = 0; h < 2; h++) begin
      for (int p = 0; p < 64; p++) begin
        @(negedge clk);
        chk_out(pp, ps);
        strobe = 1'b1; fmt = f; half = h[0]; pos = p[5:0];
        ep = 1'b0;
        es = 1'b0;
        for (int k = 0; k < 3; k++) begin
          smp[k] = {f, k[4:0], c[7:0], h[7:0], p[7:0]};
          if (owns(f, h[0], p[5:0], cfg[c][k][5:0])) begin
            if (!cfg[c][k][6] && !ep) begin
              ep = 1'b1;
              exp_pw = smp[k];
            end
            if (cfg[c][k][6] && !es) begin
              es = 1'b1;
              exp_sw = smp[k];
            end
          end
        end
        if (ep) begin
          exp_pn++;
          exp_px ^= exp_pw;
        end
        if (es) begin
          exp_sn++;
          exp_sx ^= exp_sw;
        end
        pp = ep;
        ps = es;
      end
    end
    @(negedge clk);
    strobe = 1'b0;
    chk_out(pp, ps);
  endtask

  // ==========================================================
  // watchdog sized well above the roughly sixteen hundred cycles needed
  initial begin
    repeat (6000) @(posedge clk);
    fail_count++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("reset_outs", {29'h0, rd_valid, pv, sv}, 32'h0);
    reset_n = 1'b1;
    rd(8'h00, 8'h0c, 8'h01);
    rd(8'h00, 8'h0d, 8'h02);
    rd(8'h00, 8'h0e, 8'h03);
    rd(8'h00, 8'h0b, 8'h00);
    rd(8'h01, 8'h0c, 8'h00);
    for (int c = 0; c < 3; c++) begin
      for (int k = 0; k < 3; k++) wr(8'h00, 8'h0c + 8'(k), cfg[c][k]);
      wr(8'h01, 8'h0c, 8'h3f);
      for (int k = 0; k < 3; k++) rd(8'h00, 8'h0c + 8'(k), cfg[c][k] & 8'h7f);
      for (int f = 0; f < 4; f++) stream(fmts[f], c);
    end
    @(negedge clk);
    chk("host_pri_count", 32'(pn), 32'(exp_pn));
    chk("host_sec_count", 32'(sn), 32'(exp_sn));
    chk("host_pri_sum", px, exp_px);
    chk("host_sec_sum", sx, exp_sx);
    close_out();
  end
endmodule // tb
